// [bench/pps_regs_monitor.sv]
// assertion checker for the port-2 stamp / pin / trigger slice
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_regs_monitor
	import pps_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire pps_pkg::pps_addr_t REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire pps_pkg::pps_be_t REG_BE,
	input wire pps_pkg::pps_word_t REG_WDATA,
	input wire pps_pkg::pps_word_t REG_RDATA,
	input wire logic SYNC_STAMP_VALID,
	input wire pps_pkg::pps_trig_t TRIG_EVENT,
	input wire pps_pkg::pps_gpio_t GPIO_DIR,
	input wire logic [`PPS_STAMP_W-1:0] STAMP_IRQ_STATUS,
	input wire logic TRIG_ISR_BIT,
	input wire logic TRIG_IER_BIT,
	input wire logic TRIG_IRQ
);
	import pps_pkg::*;
	// --
	// decode, bit 0 ignored as in the design
	// --
	wire logic at_mon = (REG_ADDR >> 1) == (`PPS_OFF_GPIO_MON >> 1);
	wire logic at_dir = (REG_ADDR >> 1) == (`PPS_OFF_GPIO_DIR >> 1);
	wire logic at_tis = (REG_ADDR >> 1) == (`PPS_OFF_TRIG_IS >> 1);
	wire logic at_tie = (REG_ADDR >> 1) == (`PPS_OFF_TRIG_IE >> 1);
	wire pps_gpio_t wd_pin = REG_WDATA[6:0];
	wire logic wd_any = |REG_WDATA[11:0];
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_mon_upper: assert property (REG_RD && at_mon |=> REG_RDATA[15:7] == 9'h000)
		else $error("pin monitor upper bits set");
	a_dir_write: assert property (REG_WR && at_dir && REG_BE[0] |=> GPIO_DIR == $past(wd_pin))
		else $error("direction field not written");
	a_dir_lane_hold: assert property (REG_WR && at_dir && !REG_BE[0] |=> $stable(GPIO_DIR))
		else $error("direction field changed by an unwritten lane");
	a_rsvd_trig: assert property (REG_RD && (at_tis || at_tie) |=> REG_RDATA[15:12] == 4'h0)
		else $error("trigger reserved bits set");
	a_sync_flag: assert property (SYNC_STAMP_VALID |=> STAMP_IRQ_STATUS[0])
		else $error("sync stamp flag not set");
	a_trig_set: assert property (|TRIG_EVENT |-> ##2 TRIG_ISR_BIT)
		else $error("trigger summary not raised");
	a_trig_clear: assert property (REG_WR && at_tis && REG_BE == 2'b11
		&& REG_WDATA[11:0] == 12'hfff && TRIG_EVENT == 12'h000 |-> ##2 !TRIG_ISR_BIT)
		else $error("trigger status not cleared");
	a_irq_gate: assert property (TRIG_IRQ |-> TRIG_ISR_BIT && TRIG_IER_BIT)
		else $error("irq without status and enable");
	a_ier_follow: assert property (REG_WR && at_tie && REG_BE == 2'b11
		|-> ##2 TRIG_IER_BIT == $past(wd_any, 2))
		else $error("enable summary wrong");
endmodule
bind pps_regs pps_regs_monitor mon_u (.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA),
	.REG_RDATA(REG_RDATA), .SYNC_STAMP_VALID(SYNC_STAMP_VALID), .TRIG_EVENT(TRIG_EVENT),
	.GPIO_DIR(GPIO_DIR), .STAMP_IRQ_STATUS(STAMP_IRQ_STATUS), .TRIG_ISR_BIT(TRIG_ISR_BIT),
	.TRIG_IER_BIT(TRIG_IER_BIT), .TRIG_IRQ(TRIG_IRQ));

// [bench/pps_regs_tb_top.sv]
// self-checking bench for the port-2 stamp / pin / trigger slice
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_regs_tb_top;
	import pps_pkg::*;
	logic CLK = 1'b0;
	logic NRST = 1'b0;
	pps_addr_t REG_ADDR = '0;
	logic REG_WR = 1'b0;
	logic REG_RD = 1'b0;
	pps_be_t REG_BE = '0;
	pps_word_t REG_WDATA = '0;
	pps_word_t REG_RDATA;
	logic REG_RVALID;
	logic SYNC_STAMP_VALID = 1'b0;
	logic PDR_STAMP_VALID = 1'b0;
	pps_sec_t STAMP_SEC = '0;
	pps_ns_t STAMP_NS = '0;
	pps_gpio_t GPIO_IN = '0;
	pps_trig_t TRIG_EVENT = '0;
	pps_gpio_t GPIO_DIR;
	logic [1:0] STAMP_IRQ_STATUS;
	logic TRIG_ISR_BIT, TRIG_IER_BIT, TRIG_IRQ;
	int n_fail = 0;
	int total_checks = 0;
	logic [31:0] rnd = 32'h5e00;
	int mdl [int];
	pps_regs dut_u (.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
		.REG_RD(REG_RD), .REG_BE(REG_BE), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .SYNC_STAMP_VALID(SYNC_STAMP_VALID),
		.SYNC_STAMP_SEC(STAMP_SEC), .SYNC_STAMP_NS(STAMP_NS),
		.PDR_STAMP_VALID(PDR_STAMP_VALID), .PDR_STAMP_SEC(STAMP_SEC),
		.PDR_STAMP_NS(STAMP_NS), .GPIO_IN(GPIO_IN), .TRIG_EVENT(TRIG_EVENT),
		.GPIO_DIR(GPIO_DIR), .STAMP_IRQ_STATUS(STAMP_IRQ_STATUS),
		.TRIG_ISR_BIT(TRIG_ISR_BIT), .TRIG_IER_BIT(TRIG_IER_BIT), .TRIG_IRQ(TRIG_IRQ));
	always #4 CLK = ~CLK;
	function automatic logic [31:0] nxt();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// --
	// bus tasks, the model follows every write lane by lane
	// --
	task automatic wr(input int a, input pps_be_t be, input logic [15:0] d);
		int m;
		m = {16'h0000, {8{be[1]}}, {8{be[0]}}};
		@(posedge CLK);
		REG_ADDR <= a[10:0];
		REG_BE <= be;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge CLK);
		REG_WR <= 1'b0;
		case (a)
			`PPS_OFF_GPIO_DIR: mdl[a] = ((mdl[a] & ~m) | (d & m)) & 16'h007f;
			`PPS_OFF_TRIG_IE: mdl[a] = ((mdl[a] & ~m) | (d & m)) & 16'h0fff;
			`PPS_OFF_TRIG_IS, `PPS_OFF_STAMP_IS: mdl[a] = mdl[a] & ~(d & m);
			`PPS_OFF_SYNC_LO, `PPS_OFF_SYNC_HI, `PPS_OFF_PDR_LO, `PPS_OFF_PDR_HI:
				mdl[a] = (mdl[a] & ~m) | (d & m);
			default: ;
		endcase
	endtask
	task automatic rdchk(input int a);
		@(posedge CLK);
		REG_ADDR <= a[10:0];
		REG_RD <= 1'b1;
		@(posedge CLK);
		REG_RD <= 1'b0;
		#1;
		chk({15'h0, REG_RVALID}, 16'h0001);
		chk(REG_RDATA, mdl[a][15:0]);
	endtask
	// sync and pdelay-resp share the time inputs, one valid at a time
	task automatic stamp(input int k);
		logic [31:0] r;
		int lo;
		r = nxt();
		lo = k ? `PPS_OFF_PDR_LO : `PPS_OFF_SYNC_LO;
		@(posedge CLK);
		SYNC_STAMP_VALID <= (k == 0);
		PDR_STAMP_VALID <= (k == 1);
		STAMP_SEC <= r[31:30];
		STAMP_NS <= r[29:0];
		@(posedge CLK);
		SYNC_STAMP_VALID <= 1'b0;
		PDR_STAMP_VALID <= 1'b0;
		mdl[lo] = r[15:0];
		mdl[lo + 2] = r[31:16];
		mdl[`PPS_OFF_STAMP_IS] = mdl[`PPS_OFF_STAMP_IS] | (32'h4000 << k);
		#1;
		chk({15'h0, STAMP_IRQ_STATUS[k]}, 16'h0001);
		rdchk(lo);
		rdchk(lo + 2);
	endtask
	task automatic trig(input logic [11:0] m);
		@(posedge CLK);
		TRIG_EVENT <= m;
		@(posedge CLK);
		TRIG_EVENT <= 12'h000;
		mdl[`PPS_OFF_TRIG_IS] = mdl[`PPS_OFF_TRIG_IS] | m;
	endtask
	// summary flops lag the registers by one cycle
	task automatic sums();
		int s;
		int e;
		@(posedge CLK);
		#1;
		s = mdl[`PPS_OFF_TRIG_IS];
		e = mdl[`PPS_OFF_TRIG_IE];
		chk({15'h0, TRIG_ISR_BIT}, {15'h0, s != 0});
		chk({15'h0, TRIG_IER_BIT}, {15'h0, e != 0});
		chk({15'h0, TRIG_IRQ}, {15'h0, (s & e) != 0});
		rdchk(`PPS_OFF_TRIG_IS);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// whole run is under two hundred cycles, so 2500 cycles means a hang
	initial begin
		#20000;
		n_fail++;
		complete_run();
	end
	initial begin
		int offs[$];
		logic [31:0] r;
		logic [15:0] e;
		offs = '{`PPS_OFF_SYNC_LO, `PPS_OFF_SYNC_HI, `PPS_OFF_PDR_LO, `PPS_OFF_PDR_HI,
			`PPS_OFF_GPIO_MON, `PPS_OFF_GPIO_DIR, `PPS_OFF_TRIG_IS, `PPS_OFF_TRIG_IE,
			`PPS_OFF_STAMP_IS, 11'h690};
		foreach (offs[i])
			mdl[offs[i]] = 0;
		repeat (5) @(posedge CLK);
		NRST <= 1'b1;
		foreach (offs[i])
			rdchk(offs[i]);
		$display("test reset values done");
		for (int k = 0; k < 4; k++) begin
			r = nxt();
			wr(offs[k], 2'b11, r[15:0]);
			rdchk(offs[k]);
		end
		stamp(0);
		stamp(1);
		rdchk(`PPS_OFF_STAMP_IS);
		wr(`PPS_OFF_STAMP_IS, 2'b11, 16'hc000);
		rdchk(`PPS_OFF_STAMP_IS);
		$display("test stamps done");
		for (int i = 0; i < 4; i++) begin
			r = nxt();
			@(posedge CLK);
			GPIO_IN <= r[6:0];
			repeat (3) @(posedge CLK);
			mdl[`PPS_OFF_GPIO_MON] = r[6:0];
			wr(`PPS_OFF_GPIO_MON, 2'b11, 16'hffff);
			rdchk(`PPS_OFF_GPIO_MON);
			wr(`PPS_OFF_GPIO_DIR, i[1:0], r[31:16]);
			#1;
			chk({9'h0, GPIO_DIR}, mdl[`PPS_OFF_GPIO_DIR][15:0]);
			rdchk(`PPS_OFF_GPIO_DIR);
			wr(11'h690, 2'b11, 16'hffff);
			rdchk(11'h690);
		end
		$display("test pins done");
		for (int i = 0; i < 2; i++) begin
			r = nxt();
			e = i ? 16'hf001 : {4'hf, r[11:0] | 12'h001};
			wr(`PPS_OFF_TRIG_IE, 2'b11, e);
			rdchk(`PPS_OFF_TRIG_IE);
			trig(i ? 12'h002 : r[27:16] | 12'h801);
			sums();
			wr(`PPS_OFF_TRIG_IS, 2'b11, {4'hf, r[11:0]});
			sums();
			wr(`PPS_OFF_TRIG_IS, 2'b11, 16'hffff);
			sums();
		end
		$display("test triggers done");
		complete_run();
	end
endmodule

// [inc/pps_consts.svh]
// register offsets, field positions and reset values of the port-2 stamp / pin / trigger slice
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

`define PPS_ADDR_W 11
`define PPS_LANE0_MSB 7
`define PPS_LANE1_LSB 8
`define PPS_DATA_W 16
`define PPS_BE_W 2
`define PPS_GPIO_W 7
`define PPS_TRIG_W 12
`define PPS_STAMP_W 2
`define PPS_NS_W 30
`define PPS_SEC_W 2

`define PPS_OFF_SYNC_LO 11'h66c
`define PPS_OFF_SYNC_HI 11'h66e
`define PPS_OFF_PDR_LO 11'h670
`define PPS_OFF_PDR_HI 11'h672
`define PPS_OFF_GPIO_MON 11'h680
`define PPS_OFF_GPIO_DIR 11'h682
`define PPS_OFF_TRIG_IS 11'h688
`define PPS_OFF_TRIG_IE 11'h68a
`define PPS_OFF_STAMP_IS 11'h68c

`define PPS_RST_WORD 16'h0000
`define PPS_RST_GPIO 7'h00
`define PPS_RST_TRIG 12'h000

`define PPS_NS_LO_MSB 15
`define PPS_NS_HI_MSB 29
`define PPS_NS_HI_LSB 16
`define PPS_STAMP_SYNC_BIT 14
`define PPS_STAMP_PDR_BIT 15

`endif

// [inc/pps_evt_if.sv]
// set / clear / status carrier between the register slice and a sticky status bank
`timescale 1ns/1ps
interface pps_evt_if #(parameter int W = 12);
	logic [W-1:0] set;
	logic [W-1:0] clr;
	logic [W-1:0] status;
	modport bank (input set, input clr, output status);
	modport user (output set, output clr, input status);
endinterface

// [inc/pps_pkg.sv]
// shared types of the port-2 stamp / pin / trigger register slice
`include "pps_consts.svh"
package pps_pkg;
	typedef logic [`PPS_ADDR_W-1:0] pps_addr_t;
	typedef logic [`PPS_DATA_W-1:0] pps_word_t;
	typedef logic [`PPS_BE_W-1:0] pps_be_t;
	typedef logic [`PPS_GPIO_W-1:0] pps_gpio_t;
	typedef logic [`PPS_TRIG_W-1:0] pps_trig_t;
	typedef logic [`PPS_NS_W-1:0] pps_ns_t;
	typedef logic [`PPS_SEC_W-1:0] pps_sec_t;
endpackage

// [rtl/pps_regs.sv]
// port-2 egress stamps, pin monitor / direction and trigger-unit interrupt registers
// Function
// - sync stamp low word holds ns 15:0, resets zero, software read-write
// - sync stamp high word: seconds 1:0 in 15:14, ns 29:16 in 13:0
// - pdelay-resp stamp low word holds ns 15:0, resets zero
// - pdelay-resp stamp high word: seconds 1:0 in 15:14, ns 29:16 in 13:0
// - sync stamp arrival sets stamp-unit status bit 14, cleared by writing one
// - pin monitor read-only, bits 6:0 show pins 6..0, upper bits reserved
// - direction bit zero means trigger output, one means stamp input; resets zero
// - trigger unit done or error sets status bit; units 1..12 on bits 0..11
// - writing one clears a trigger status bit, writing zero leaves it
// - OR of twelve trigger status bits drives chip status bit 10
// - trigger enables in bits 11:0, reset zero; their OR drives chip enable bit 10
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_regs
	import pps_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire pps_pkg::pps_addr_t REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire pps_pkg::pps_be_t REG_BE,
	input wire pps_pkg::pps_word_t REG_WDATA,
	output pps_pkg::pps_word_t REG_RDATA,
	output logic REG_RVALID,
	input wire logic SYNC_STAMP_VALID,
	input wire pps_pkg::pps_sec_t SYNC_STAMP_SEC,
	input wire pps_pkg::pps_ns_t SYNC_STAMP_NS,
	input wire logic PDR_STAMP_VALID,
	input wire pps_pkg::pps_sec_t PDR_STAMP_SEC,
	input wire pps_pkg::pps_ns_t PDR_STAMP_NS,
	input wire pps_pkg::pps_gpio_t GPIO_IN,
	input wire pps_pkg::pps_trig_t TRIG_EVENT,
	output pps_pkg::pps_gpio_t GPIO_DIR,
	output logic [`PPS_STAMP_W-1:0] STAMP_IRQ_STATUS,
	output logic TRIG_ISR_BIT,
	output logic TRIG_IER_BIT,
	output logic TRIG_IRQ
);
	import pps_pkg::*;

	// ----------------------------------------------------------------
	// byte-lane merge
	// ----------------------------------------------------------------
	function automatic pps_word_t lane_merge(input pps_word_t old, input pps_word_t wd,
		input pps_be_t be);
		pps_word_t res;
		res = old;
		if (be[0]) begin
			res[`PPS_LANE0_MSB:0] = wd[`PPS_LANE0_MSB:0];
		end
		if (be[1]) begin
			res[`PPS_DATA_W-1:`PPS_LANE1_LSB] = wd[`PPS_DATA_W-1:`PPS_LANE1_LSB];
		end
		return res;
	endfunction

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	// bit 0 is dropped from the decode; lanes come from REG_BE
	pps_addr_t word_addr;
	assign word_addr = {REG_ADDR[`PPS_ADDR_W-1:1], 1'b0};

	// one compare per register; an offset that hits nothing reads zero
	logic hit_sync_lo;
	logic hit_sync_hi;
	logic hit_pdr_lo;
	logic hit_pdr_hi;
	logic hit_gpio_mon;
	logic hit_gpio_dir;
	logic hit_trig_is;
	logic hit_trig_ie;
	logic hit_stamp_is;
	assign hit_sync_lo = (word_addr == `PPS_OFF_SYNC_LO);
	assign hit_sync_hi = (word_addr == `PPS_OFF_SYNC_HI);
	assign hit_pdr_lo = (word_addr == `PPS_OFF_PDR_LO);
	assign hit_pdr_hi = (word_addr == `PPS_OFF_PDR_HI);
	assign hit_gpio_mon = (word_addr == `PPS_OFF_GPIO_MON);
	assign hit_gpio_dir = (word_addr == `PPS_OFF_GPIO_DIR);
	assign hit_trig_is = (word_addr == `PPS_OFF_TRIG_IS);
	assign hit_trig_ie = (word_addr == `PPS_OFF_TRIG_IE);
	assign hit_stamp_is = (word_addr == `PPS_OFF_STAMP_IS);

	// no write strobe for the monitor: it is read-only
	logic wr_sync_lo;
	logic wr_sync_hi;
	logic wr_pdr_lo;
	logic wr_pdr_hi;
	logic wr_gpio_dir;
	logic wr_trig_is;
	logic wr_trig_ie;
	logic wr_stamp_is;
	assign wr_sync_lo = REG_WR & hit_sync_lo;
	assign wr_sync_hi = REG_WR & hit_sync_hi;
	assign wr_pdr_lo = REG_WR & hit_pdr_lo;
	assign wr_pdr_hi = REG_WR & hit_pdr_hi;
	assign wr_gpio_dir = REG_WR & hit_gpio_dir;
	assign wr_trig_is = REG_WR & hit_trig_is;
	assign wr_trig_ie = REG_WR & hit_trig_ie;
	assign wr_stamp_is = REG_WR & hit_stamp_is;

	// only written lanes can clear or change bits
	pps_word_t wr_lanes;
	assign wr_lanes = lane_merge(`PPS_RST_WORD, REG_WDATA, REG_BE);

	// ----------------------------------------------------------------
	// egress stamp words
	// ----------------------------------------------------------------
	pps_word_t sync_lo;
	pps_word_t sync_hi;
	pps_word_t pdr_lo;
	pps_word_t pdr_hi;
	pps_word_t next_sync_lo;
	pps_word_t next_sync_hi;
	pps_word_t next_pdr_lo;
	pps_word_t next_pdr_hi;

	// capture beats a same-cycle software write: the fresh stamp is worth more
	pps_word_t cap_sync_lo;
	pps_word_t cap_sync_hi;
	pps_word_t cap_pdr_lo;
	pps_word_t cap_pdr_hi;
	assign cap_sync_lo = SYNC_STAMP_NS[`PPS_NS_LO_MSB:0];
	assign cap_sync_hi = {SYNC_STAMP_SEC, SYNC_STAMP_NS[`PPS_NS_HI_MSB:`PPS_NS_HI_LSB]};
	assign cap_pdr_lo = PDR_STAMP_NS[`PPS_NS_LO_MSB:0];
	assign cap_pdr_hi = {PDR_STAMP_SEC, PDR_STAMP_NS[`PPS_NS_HI_MSB:`PPS_NS_HI_LSB]};

	assign next_sync_lo = SYNC_STAMP_VALID ? cap_sync_lo :
		(wr_sync_lo ? lane_merge(sync_lo, REG_WDATA, REG_BE) : sync_lo);
	assign next_sync_hi = SYNC_STAMP_VALID ? cap_sync_hi :
		(wr_sync_hi ? lane_merge(sync_hi, REG_WDATA, REG_BE) : sync_hi);
	assign next_pdr_lo = PDR_STAMP_VALID ? cap_pdr_lo :
		(wr_pdr_lo ? lane_merge(pdr_lo, REG_WDATA, REG_BE) : pdr_lo);
	assign next_pdr_hi = PDR_STAMP_VALID ? cap_pdr_hi :
		(wr_pdr_hi ? lane_merge(pdr_hi, REG_WDATA, REG_BE) : pdr_hi);

	// low and high words have no shadow latch; read both after a stamp
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			sync_lo <= `PPS_RST_WORD;
			sync_hi <= `PPS_RST_WORD;
		end else begin
			sync_lo <= next_sync_lo;
			sync_hi <= next_sync_hi;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pdr_lo <= `PPS_RST_WORD;
			pdr_hi <= `PPS_RST_WORD;
		end else begin
			pdr_lo <= next_pdr_lo;
			pdr_hi <= next_pdr_hi;
		end
	end

	// ----------------------------------------------------------------
	// stamp-unit status, port-2 bits only
	// ----------------------------------------------------------------
	// other stamp units sit outside this slice, so only bits 15:14 exist here
	pps_evt_if #(.W(`PPS_STAMP_W)) stamp_evt ();
	pps_word_t stamp_clr_word;
	assign stamp_clr_word = wr_stamp_is ? wr_lanes : `PPS_RST_WORD;
	assign stamp_evt.set = {PDR_STAMP_VALID, SYNC_STAMP_VALID};
	assign stamp_evt.clr = stamp_clr_word[`PPS_STAMP_PDR_BIT:`PPS_STAMP_SYNC_BIT];

	pps_w1c_bank #(.W(`PPS_STAMP_W)) u_stamp_bank (
		.clk(CLK),
		.nrst(NRST),
		.evt(stamp_evt.bank)
	);
	assign STAMP_IRQ_STATUS = stamp_evt.status;

	// ----------------------------------------------------------------
	// pin monitor and direction
	// ----------------------------------------------------------------
	// pins are asynchronous: the monitor lags a pin change by two clocks
	pps_gpio_t gpio_sync;
	pps_sync2 #(.W(`PPS_GPIO_W)) u_gpio_sync (
		.clk(CLK),
		.nrst(NRST),
		.async_in(GPIO_IN),
		.sync_out(gpio_sync)
	);

	pps_gpio_t gpio_dir;
	pps_gpio_t next_gpio_dir;
	// merge on the padded word, then keep only the field bits
	pps_word_t dir_merged;
	assign dir_merged = lane_merge({{(`PPS_DATA_W-`PPS_GPIO_W){1'b0}}, gpio_dir},
		REG_WDATA, REG_BE);
	assign next_gpio_dir = wr_gpio_dir ? dir_merged[`PPS_GPIO_W-1:0] : gpio_dir;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			gpio_dir <= `PPS_RST_GPIO;
		end else begin
			gpio_dir <= next_gpio_dir;
		end
	end
	// zero drives the pin as a trigger output, one hands it to a stamp input
	assign GPIO_DIR = gpio_dir;

	// ----------------------------------------------------------------
	// trigger-unit interrupt status and enable
	// ----------------------------------------------------------------
	pps_evt_if #(.W(`PPS_TRIG_W)) trig_evt ();
	pps_word_t trig_clr_word;
	assign trig_clr_word = wr_trig_is ? wr_lanes : `PPS_RST_WORD;
	assign trig_evt.set = TRIG_EVENT;
	assign trig_evt.clr = trig_clr_word[`PPS_TRIG_W-1:0];

	// an event in the cycle of its clear survives
	pps_w1c_bank #(.W(`PPS_TRIG_W)) u_trig_bank (
		.clk(CLK),
		.nrst(NRST),
		.evt(trig_evt.bank)
	);

	// enables mask only the host interrupt; status still collects events
	pps_trig_t trig_en;
	pps_trig_t next_trig_en;
	pps_word_t en_merged;
	assign en_merged = lane_merge({{(`PPS_DATA_W-`PPS_TRIG_W){1'b0}}, trig_en},
		REG_WDATA, REG_BE);
	assign next_trig_en = wr_trig_ie ? en_merged[`PPS_TRIG_W-1:0] : trig_en;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			trig_en <= `PPS_RST_TRIG;
		end else begin
			trig_en <= next_trig_en;
		end
	end

	// summaries lag the status flops by one cycle so every output is a flop
	logic next_isr_bit;
	logic next_ier_bit;
	logic next_irq;
	assign next_isr_bit = |trig_evt.status;
	assign next_ier_bit = |trig_en;
	assign next_irq = |(trig_evt.status & trig_en);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			TRIG_ISR_BIT <= 1'b0;
			TRIG_IER_BIT <= 1'b0;
			TRIG_IRQ <= 1'b0;
		end else begin
			TRIG_ISR_BIT <= next_isr_bit;
			TRIG_IER_BIT <= next_ier_bit;
			TRIG_IRQ <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	// narrow fields pad with zero; unmapped offsets also read zero
	pps_word_t rd_gpio_mon;
	pps_word_t rd_gpio_dir;
	pps_word_t rd_trig_is;
	pps_word_t rd_trig_ie;
	pps_word_t rd_stamp_is;
	assign rd_gpio_mon = {{(`PPS_DATA_W-`PPS_GPIO_W){1'b0}}, gpio_sync};
	assign rd_gpio_dir = {{(`PPS_DATA_W-`PPS_GPIO_W){1'b0}}, gpio_dir};
	assign rd_trig_is = {{(`PPS_DATA_W-`PPS_TRIG_W){1'b0}}, trig_evt.status};
	assign rd_trig_ie = {{(`PPS_DATA_W-`PPS_TRIG_W){1'b0}}, trig_en};
	assign rd_stamp_is = {stamp_evt.status, {(`PPS_DATA_W-`PPS_STAMP_W){1'b0}}};

	// priority order is harmless: the hit lines are mutually exclusive
	pps_word_t rd_mux;
	assign rd_mux = hit_sync_lo ? sync_lo :
		hit_sync_hi ? sync_hi :
		hit_pdr_lo ? pdr_lo :
		hit_pdr_hi ? pdr_hi :
		hit_gpio_mon ? rd_gpio_mon :
		hit_gpio_dir ? rd_gpio_dir :
		hit_trig_is ? rd_trig_is :
		hit_trig_ie ? rd_trig_ie :
		hit_stamp_is ? rd_stamp_is : `PPS_RST_WORD;

	// read data holds between reads; REG_RVALID marks every read, mapped or not
	pps_word_t next_rdata;
	assign next_rdata = REG_RD ? rd_mux : REG_RDATA;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			REG_RDATA <= `PPS_RST_WORD;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RDATA <= next_rdata;
			REG_RVALID <= REG_RD;
		end
	end
endmodule

// [rtl/pps_sync2.sv]
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ps
module pps_sync2 #(parameter int W = 7) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta;

	// meta feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					meta[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end else begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// [rtl/pps_w1c_bank.sv]
// sticky status bits, set by hardware, cleared by writing one
`timescale 1ns/1ps
module pps_w1c_bank #(parameter int W = 12) (
	input wire logic clk,
	input wire logic nrst,
	pps_evt_if.bank evt
);
	// a set in the cycle of a clear wins, so no event is lost
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic next_bit;
			assign next_bit = evt.set[i] | (evt.status[i] & ~evt.clr[i]);
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					evt.status[i] <= 1'b0;
				end else begin
					evt.status[i] <= next_bit;
				end
			end
		end
	endgenerate
endmodule
